// *** common/der_pkg.sv ***
// Purpose: constants, codes and carriers of the disk error reporting block
// Assumes: one 50 MHz clock, asynchronous active-high reset
// Notes:   every error code is one byte; 00 means a clean command
//
// Summary of operation
// - code returned in sense or message; 00 clean
// - ECC span beyond burst length gives 11
// - no address mark within window gives 12
// - sector unseen after two revolutions gives 14
// - ID cylinder/head mismatch after seek gives 15
// - ECC-repaired media error gives 18
// - transfer onto flagged bad track gives 19
// - unformatted, interleave or ID ECC gives 1A
// - clean reread after data error gives 1B
// - alternate already taken or bad gives 1D
// - alternate lacking alternate flag gives 1E
// - alternate equal to defective gives 1F
// - unknown opcode gives 20
// - address beyond drive range gives 21
// - bad parameter or combination gives 22
// - buffer RAM diagnostic mismatch gives 30
// - more than 20 errors aborts command
package der_pkg;

   // timing
   localparam int CLK_PERIOD_NS = 20;
   localparam int AM_WINDOW_NS  = 2000;                       // longest wait for a mark
   localparam int AM_WINDOW_INT = (AM_WINDOW_NS / CLK_PERIOD_NS < 1) ? 1
                                  : AM_WINDOW_NS / CLK_PERIOD_NS;
   localparam logic [7:0] AM_WINDOW_CYC = 8'(AM_WINDOW_INT);  // rounds down
   localparam logic [1:0] SEARCH_REVS   = 2'h2;
   localparam logic [4:0] ERR_LIMIT     = 5'h14;              // 20 errors allowed

   // error codes
   localparam logic [7:0] ERR_NONE      = 8'h00;
   localparam logic [7:0] ERR_UNCORR    = 8'h11;
   localparam logic [7:0] ERR_AM_MISS   = 8'h12;
   localparam logic [7:0] ERR_NOT_FOUND = 8'h14;
   localparam logic [7:0] ERR_SEEK      = 8'h15;
   localparam logic [7:0] ERR_CORR      = 8'h18;
   localparam logic [7:0] ERR_BAD_TRK   = 8'h19;
   localparam logic [7:0] ERR_FORMAT    = 8'h1A;
   localparam logic [7:0] ERR_TRANSIENT = 8'h1B;
   localparam logic [7:0] ERR_ALT_BUSY  = 8'h1D;
   localparam logic [7:0] ERR_ALT_NOFMT = 8'h1E;
   localparam logic [7:0] ERR_ALT_SAME  = 8'h1F;
   localparam logic [7:0] ERR_BAD_CMD   = 8'h20;
   localparam logic [7:0] ERR_BAD_ADDR  = 8'h21;
   localparam logic [7:0] ERR_BAD_PARAM = 8'h22;
   localparam logic [7:0] ERR_RAM_DIAG  = 8'h30;
   localparam logic [7:0] ERR_LIMIT_HIT = 8'h33;

   // opcode space
   localparam logic [7:0] CMD_LAST  = 8'h1F;
   localparam logic [7:0] CMD_READ  = 8'h08;
   localparam logic [7:0] CMD_WRITE = 8'h0A;

   typedef struct packed {
      logic [15:0] cyl;
      logic [7:0]  head;
   } der_trk_s;

   typedef struct packed {
      logic [7:0] opcode;
      der_trk_s   trk;
      logic [7:0] sector;
   } der_cmd_s;

   typedef struct packed {
      der_trk_s   trk;
      logic [7:0] sector;
      logic       altFlag;   // track formatted as an alternate
      logic       badFlag;   // track flagged defective
   } der_id_s;

   typedef struct packed {
      logic [15:0] maxCyl;
      logic [7:0]  maxHead;
      logic [7:0]  burstLen;  // correctable span set at drive initialisation
   } der_cfg_s;

   // one bit per error cause, highest priority first
   typedef struct packed {
      logic badCmd;
      logic badAddr;
      logic badParam;
      logic ramDiag;
      logic altSame;
      logic altBusy;
      logic altNoFmt;
      logic badTrk;
      logic seekMis;
      logic notFound;
      logic amMiss;
      logic fmt;
      logic uncorr;
      logic corr;
      logic transient;
   } der_err_s;

   typedef enum logic [0:0] {
      ST_IDLE = 1'b0,
      ST_RUN  = 1'b1
   } der_st_e;

   typedef struct packed {
      der_st_e    st;
      logic [7:0] senseCode;
      logic [7:0] cmdCode;
      logic [7:0] msgCode;
      logic       msgValid;
      logic       abort;
      logic [4:0] errCnt;
      logic       retryArmed;
   } der_state_s;

   typedef struct packed {
      logic       active;
      logic [7:0] amCnt;
      logic [1:0] revCnt;
   } der_srch_s;

   typedef struct packed {
      logic meta;
      logic stable;
      logic last;
   } der_sync_s;

   function automatic logic der_cmd_valid(input logic [7:0] op);
      der_cmd_valid = (op <= CMD_LAST);
   endfunction

   function automatic logic der_is_xfer(input logic [7:0] op);
      der_is_xfer = (op == CMD_READ) || (op == CMD_WRITE);
   endfunction

endpackage

// *** design/der_pin_sync.sv ***
// Purpose: bring a drive pin into the clock domain and mark its rising edge
// Assumes: pin is asynchronous to clk_sys
// Notes:   edge detection looks only at the second stage and later
module der_pin_sync
   import der_pkg::*;
(
   input  wire logic clk_sys,   // system clock
   input  wire logic rst,       // asynchronous reset
   input  wire logic pinIn,     // raw drive pin
   output logic      risePulse  // one cycle on a rising edge
);
   der_sync_s s_q;
   der_sync_s s_d;

   // shift chain; meta feeds stable only
   always_comb begin
      s_d        = s_q;
      s_d.meta   = pinIn;
      s_d.stable = s_q.meta;
      s_d.last   = s_q.stable;
   end

   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         s_q <= '0;
      end else begin
         s_q <= s_d;
      end
   end

   assign risePulse = s_q.stable & ~s_q.last;
endmodule

// *** design/der_sector_search.sv ***
// Purpose: watch address marks, index and ID fields while a sector is sought
// Assumes: idValid and id come from the read channel on clk_sys
// Notes:   each search ends on at most one outcome pulse; a clean sector match ends it silently
module der_sector_search
   import der_pkg::*;
(
   input  wire logic     clk_sys,      // system clock
   input  wire logic     rst,          // asynchronous reset
   input  wire logic     start,        // begin a search
   input  der_cmd_s      target,       // sought track and sector
   input  wire logic     indexPulse,   // synchronised index edge
   input  wire logic     amPulse,      // synchronised address mark edge
   input  wire logic     idValid,      // an ID field was read
   input  wire logic     idEccErr,     // that ID field failed its check
   input  der_id_s       id,           // the ID field contents
   output logic          amMissing,    // mark window expired
   output logic          notFound,     // revolutions used up
   output logic          seekMismatch, // wrong cylinder or head
   output logic          badTrack,     // target on flagged track
   output logic          searching     // search in progress
);
   der_srch_s s_q;
   der_srch_s s_d;

   // outcome selection; an ID read that ends the search outranks the timers
   always_comb begin
      s_d          = s_q;
      amMissing    = 1'b0;
      notFound     = 1'b0;
      seekMismatch = 1'b0;
      badTrack     = 1'b0;
      if (start) begin
         s_d = '{active: 1'b1, amCnt: 8'h00, revCnt: 2'h0};
      end else if (s_q.active) begin
         s_d.amCnt = amPulse ? 8'h00 : s_q.amCnt + 8'h01;
         if (indexPulse) begin
            s_d.revCnt = s_q.revCnt + 2'h1;
         end
         if (idValid && !idEccErr && id.trk != target.trk) begin
            seekMismatch = 1'b1;
            s_d.active   = 1'b0;
         end else if (idValid && !idEccErr && id.sector == target.sector) begin
            badTrack   = id.badFlag;
            s_d.active = 1'b0;
         end else if (indexPulse && s_q.revCnt == SEARCH_REVS - 2'h1) begin
            notFound   = 1'b1;
            s_d.active = 1'b0;
         end else if (!amPulse && s_q.amCnt == AM_WINDOW_CYC - 8'h01) begin
            amMissing  = 1'b1;
            s_d.active = 1'b0;
         end
      end
   end

   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         s_q <= '0;
      end else begin
         s_q <= s_d;
      end
   end

   assign searching = s_q.active;
endmodule

// *** design/der_error_report.sv ***
// Purpose: classify disk command errors into one reported byte
// Assumes: event inputs are one-cycle pulses from logic on clk_sys;
//          drive index and address mark arrive on raw pins
// Notes:   several causes in one cycle report the highest priority one
//          search outcomes count only while a command runs
module der_error_report
   import der_pkg::*;
(
   input  wire logic     clk_sys,     // 50 MHz system clock
   input  wire logic     rst,         // asynchronous reset
   input  wire logic     cmdStart,    // host command accepted
   input  der_cmd_s      cmd,         // command held while it runs
   input  der_cfg_s      cfg,         // drive characteristics
   input  wire logic     paramBad,    // parameter checker flags cmd
   input  wire logic     cmdDone,     // execution finished
   input  wire logic     indexPin,    // drive index pin
   input  wire logic     addrMarkPin, // drive address mark pin
   input  wire logic     idValid,     // ID field read
   input  der_id_s       id,          // ID field contents
   input  wire logic     idEccErr,    // ID field check failed
   input  wire logic     fmtErr,      // unformatted track or interleave
   input  wire logic     dataDone,    // data field read finished
   input  wire logic     dataErr,     // data field had an ECC syndrome
   input  wire logic [7:0] errSpan,   // measured error span
   input  wire logic     retryRead,   // current read is a retry
   input  wire logic     assignReq,   // alternate assignment checked
   input  der_trk_s      altTrk,      // proposed alternate track
   input  wire logic     altAssigned, // alternate already in use
   input  wire logic     altIsBad,    // alternate formatted defective
   input  wire logic     altIdFlag,   // alternate ID carries alternate bit
   input  wire logic     ramDiagErr,  // buffer RAM diagnostic mismatch
   input  wire logic     senseRd,     // host reads sense status
   output logic [7:0]    senseCode,   // sticky code for sense status
   output logic [7:0]    msgCode,     // completion message byte
   output logic          msgValid,    // message byte pulse
   output logic          abortCmd,    // command aborted on error count
   output logic          busy         // command running
);
   der_state_s s_q;
   der_state_s s_d;
   der_err_s   evt;
   logic       anyErr;
   logic       indexPulse;
   logic       amPulse;
   logic       amMissing;
   logic       notFound;
   logic       seekMismatch;
   logic       badTrack;
   logic       searching;
   logic       cmdOk;
   logic       addrOk;
   logic       spanTooBig;
   logic       cmdTake;
   logic       searchGo;

   // picks the code of the highest priority cause present
   function automatic logic [7:0] der_pick(input der_err_s e);
      if (e.badCmd)         der_pick = ERR_BAD_CMD;
      else if (e.badAddr)   der_pick = ERR_BAD_ADDR;
      else if (e.badParam)  der_pick = ERR_BAD_PARAM;
      else if (e.ramDiag)   der_pick = ERR_RAM_DIAG;
      else if (e.altSame)   der_pick = ERR_ALT_SAME;
      else if (e.altBusy)   der_pick = ERR_ALT_BUSY;
      else if (e.altNoFmt)  der_pick = ERR_ALT_NOFMT;
      else if (e.badTrk)    der_pick = ERR_BAD_TRK;
      else if (e.seekMis)   der_pick = ERR_SEEK;
      else if (e.notFound)  der_pick = ERR_NOT_FOUND;
      else if (e.amMiss)    der_pick = ERR_AM_MISS;
      else if (e.fmt)       der_pick = ERR_FORMAT;
      else if (e.uncorr)    der_pick = ERR_UNCORR;
      else if (e.corr)      der_pick = ERR_CORR;
      else if (e.transient) der_pick = ERR_TRANSIENT;
      else                  der_pick = ERR_NONE;
   endfunction

   // drive pins cross into the clock domain before any use
   der_pin_sync u_index_sync (
      .clk_sys   (clk_sys),
      .rst       (rst),
      .pinIn     (indexPin),
      .risePulse (indexPulse)
   );

   der_pin_sync u_am_sync (
      .clk_sys   (clk_sys),
      .rst       (rst),
      .pinIn     (addrMarkPin),
      .risePulse (amPulse)
   );

   // a search runs only for well formed transfer commands
   der_sector_search u_search (
      .clk_sys      (clk_sys),
      .rst          (rst),
      .start        (searchGo),
      .target       (cmd),
      .indexPulse   (indexPulse),
      .amPulse      (amPulse),
      .idValid      (idValid),
      .idEccErr     (idEccErr),
      .id           (id),
      .amMissing    (amMissing),
      .notFound     (notFound),
      .seekMismatch (seekMismatch),
      .badTrack     (badTrack),
      .searching    (searching)
   );

   // command checks; address is only judged on a known opcode
   assign cmdOk      = der_cmd_valid(cmd.opcode);
   assign addrOk     = (cmd.trk.cyl <= cfg.maxCyl) && (cmd.trk.head <= cfg.maxHead);
   assign spanTooBig = errSpan > cfg.burstLen;

   // nothing is taken from a command offered while busy
   assign cmdTake    = cmdStart & ~busy;
   assign searchGo   = cmdTake & cmdOk & addrOk & ~paramBad & der_is_xfer(cmd.opcode);

   // cause vector; alternate checks are exclusive in the order below
   always_comb begin
      evt           = '0;
      evt.badCmd    = cmdTake & ~cmdOk;
      evt.badAddr   = cmdTake & cmdOk & ~addrOk;
      evt.badParam  = cmdTake & cmdOk & addrOk & paramBad;
      evt.ramDiag   = ramDiagErr;
      evt.altSame   = assignReq & (altTrk == cmd.trk);
      evt.altBusy   = assignReq & (altTrk != cmd.trk)
                      & (altAssigned | altIsBad);
      evt.altNoFmt  = assignReq & (altTrk != cmd.trk)
                      & ~altAssigned & ~altIsBad & ~altIdFlag;
      // a search left running after completion must stay silent
      evt.badTrk    = badTrack & busy;
      evt.seekMis   = seekMismatch & busy;
      evt.notFound  = notFound & busy;
      evt.amMiss    = amMissing & busy;
      evt.fmt       = fmtErr | (idValid & idEccErr);
      evt.uncorr    = dataDone & dataErr & spanTooBig;
      evt.corr      = dataDone & dataErr & ~spanTooBig;
      evt.transient = dataDone & ~dataErr & retryRead
                      & s_q.retryArmed;
   end

   // several causes in one cycle still count as one error
   assign anyErr = |evt;

   // sequencing, error count and code capture
   always_comb begin
      s_d          = s_q;
      s_d.msgValid = 1'b0;
      s_d.abort    = 1'b0;
      // a read clears the sticky code, but a same-cycle error wins
      if (senseRd) begin
         s_d.senseCode = ERR_NONE;
      end
      if (anyErr) begin
         s_d.senseCode = der_pick(evt);
         s_d.cmdCode   = der_pick(evt);
      end
      // only a failed read arms the transient report
      if (dataDone) begin
         s_d.retryArmed = dataErr;
      end
      case (s_q.st)
         ST_IDLE: begin
            if (cmdStart) begin
               s_d.errCnt     = 5'h00;
               s_d.retryArmed = 1'b0;
               if (anyErr) begin
                  // rejected commands complete at once with their code
                  s_d.msgCode  = der_pick(evt);
                  s_d.msgValid = 1'b1;
               end else begin
                  s_d.cmdCode = ERR_NONE;
                  s_d.st      = ST_RUN;
               end
            end
         end
         ST_RUN: begin
            if (anyErr) begin
               s_d.errCnt = s_q.errCnt + 5'h01;
            end
            if (anyErr && s_q.errCnt == ERR_LIMIT) begin
               // retries cannot go on forever; 21st error ends it
               s_d.senseCode = ERR_LIMIT_HIT;
               s_d.msgCode   = ERR_LIMIT_HIT;
               s_d.msgValid  = 1'b1;
               s_d.abort     = 1'b1;
               s_d.st        = ST_IDLE;
            end else if (cmdDone) begin
               s_d.msgCode  = s_d.cmdCode;
               s_d.msgValid = 1'b1;
               s_d.st       = ST_IDLE;
            end
         end
         default: begin
            s_d.st = ST_IDLE;
         end
      endcase
   end

   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         s_q <= '{st: ST_IDLE, senseCode: ERR_NONE, cmdCode: ERR_NONE,
                  msgCode: ERR_NONE, default: '0};
      end else begin
         s_q <= s_d;
      end
   end

   assign senseCode = s_q.senseCode;
   assign msgCode   = s_q.msgCode;
   assign msgValid  = s_q.msgValid;
   assign abortCmd  = s_q.abort;
   assign busy      = (s_q.st == ST_RUN);

   // checks on the reported codes
   default clocking cbDef @(posedge clk_sys); endclocking
   default disable iff (rst);

   logic evtSingle;
   assign evtSingle = $onehot(evt);

   sequence sOnly(logic cause);
      cause && evtSingle && !(busy && s_q.errCnt == ERR_LIMIT);
   endsequence

   sequence sCleanDone;
      s_q.st == ST_RUN && cmdDone && !anyErr && s_q.cmdCode == ERR_NONE;
   endsequence

   property pSense(logic cause, logic [7:0] code);
      sOnly(cause) |=> senseCode == code;
   endproperty

   AST_CLEAN_DONE: assert property (sCleanDone |=> msgValid && msgCode == ERR_NONE)
      else $error("clean command did not report code 00");
   AST_UNCORR: assert property (pSense(evt.uncorr, 8'h11))
      else $error("uncorrectable data error not reported as 11");
   AST_AM_MISS: assert property (pSense(evt.amMiss, 8'h12))
      else $error("missing address mark not reported as 12");
   AST_NOT_FOUND: assert property (pSense(evt.notFound, 8'h14))
      else $error("sector not found not reported as 14");
   AST_SEEK: assert property (pSense(evt.seekMis, 8'h15))
      else $error("seek mismatch not reported as 15");
   AST_CORR: assert property (sOnly(evt.corr) ##0 !cmdDone
                              |=> senseCode == 8'h18 && !msgValid)
      else $error("corrected data error not reported as 18");
   AST_FORMAT: assert property (pSense(evt.fmt, 8'h1A))
      else $error("format error not reported as 1A");
   AST_ALT_SAME: assert property (pSense(evt.altSame, 8'h1F))
      else $error("alternate equal to defective not reported as 1F");
   AST_BAD_CMD: assert property (s_q.st == ST_IDLE && cmdStart && !cmdOk
                                 |=> msgValid && msgCode == 8'h20 && !busy)
      else $error("invalid opcode not rejected with 20");
   AST_LIMIT: assert property (busy && anyErr && s_q.errCnt == 5'h14
                               |=> abortCmd && msgCode == 8'h33 ##1 !busy)
      else $error("error limit did not abort with 33");
   AST_HOLD: assert property (!anyErr && !senseRd |=> $stable(senseCode))
      else $error("sense code changed without cause");

   // rejected commands finish on the next edge and never run
   sequence sReject(logic cause);
      cause && evtSingle && !busy;
   endsequence

   property pReject(logic cause, logic [7:0] code);
      sReject(cause) |=> msgValid && msgCode == code && senseCode == code && !busy;
   endproperty

   AST_BAD_ADDR: assert property (pReject(evt.badAddr, 8'h21))
      else $error("bad address not rejected");

   AST_BAD_PARAM: assert property (pReject(evt.badParam, 8'h22))
      else $error("bad parameter not rejected");

   AST_CLEAN_START: assert property (!busy && cmdStart && !anyErr |=> busy && !msgValid)
      else $error("clean command did not start");

   // outcomes while running
   AST_BAD_TRK: assert property (pSense(evt.badTrk, 8'h19))
      else $error("flagged track not reported");

   AST_TRANSIENT: assert property (pSense(evt.transient, 8'h1B))
      else $error("clean retry not reported");

   AST_ALT_BUSY: assert property (pSense(evt.altBusy, 8'h1D))
      else $error("busy alternate not reported");

   AST_ALT_NOFMT: assert property (pSense(evt.altNoFmt, 8'h1E))
      else $error("unflagged alternate not reported");

   AST_CNT_BOUND: assert property (busy |-> s_q.errCnt <= ERR_LIMIT)
      else $error("error count past limit");

   // idle diagnostics and status reads touch the sense code only
   AST_RAM_DIAG: assert property (ramDiagErr && evtSingle && !busy && !cmdStart
                                  |=> senseCode == 8'h30 && !msgValid)
      else $error("RAM mismatch not reported");

   AST_SENSE_CLEAR: assert property (senseRd && !anyErr |=> senseCode == 8'h00)
      else $error("status read kept the code");
endmodule

// *** test/der_host_model.sv ***
// Purpose: host side model that issues disk commands and reads sense status
// Assumes: requests change just after a rising edge of clk_sys
// Notes:   the caller picks each track from its own table of usable tracks
module der_host_model
   import der_pkg::*;
(
   input  wire logic clk_sys,  // system clock
   output logic      cmdStart, // command strobe
   output der_cmd_s  cmd,      // command, held until the next one
   output logic      senseRd   // sense status read strobe
);
   timeunit 1ns;
   timeprecision 1ns;

   // quiet host at time zero
   initial begin
      cmdStart = 1'b0;
      senseRd  = 1'b0;
      cmd      = '0;
   end

   // one-cycle strobe; cmd stays put so the device can keep comparing it
   task automatic issue(input logic [7:0] op, input logic [15:0] cyl, input logic [7:0] hd);
      @(posedge clk_sys);
      cmdStart <= 1'b1;
      cmd      <= '{op, '{cyl, hd}, 8'h03}; // deleted tracks only on purpose
      @(posedge clk_sys);
      cmdStart <= 1'b0;
   endtask

   // reading status releases the sticky code
   task automatic readSense();
      @(posedge clk_sys);
      senseRd <= 1'b1;
      @(posedge clk_sys);
      senseRd <= 1'b0;
   endtask
endmodule

// *** test/der_error_report_bench.sv ***
// Purpose: self-checking bench of the disk error reporting block
// Assumes: host model issues commands, bench plays the drive and data path
// Notes:   each command ends well inside the 100-cycle mark window, save in the mark window test
module der_error_report_bench
   import der_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ns;

`define CHK(nm, e, g) begin nCompared++; if ((g) !== (e)) begin errCount++; \
   $display("mismatch %s expected %h seen %h", nm, e, g); end end

   localparam int FMT = 0, IDV = 1, DAT = 2, ASG = 3, DONE = 4, RAM = 5;
   logic clk_sys, rst, paramBad, cmdDone, indexPin, addrMarkPin, idValid, idEccErr;
   logic fmtErr, dataDone, dataErr, retryRead, assignReq, altAssigned, altIsBad;
   logic altIdFlag, ramDiagErr, cmdStart, senseRd, msgValid, abortCmd, busy;
   logic [7:0] errSpan, senseCode, msgCode;
   der_cmd_s   cmd;
   der_id_s    id;
   der_trk_s   altTrk;
   der_cfg_s   cfg;
   int         errCount, nCompared, cycles;

   der_host_model host (.clk_sys, .cmdStart, .cmd, .senseRd);
   der_error_report dut (.clk_sys, .rst, .cmdStart, .cmd, .cfg, .paramBad, .cmdDone,
      .indexPin, .addrMarkPin, .idValid, .id, .idEccErr, .fmtErr, .dataDone, .dataErr,
      .errSpan, .retryRead, .assignReq, .altTrk, .altAssigned, .altIsBad, .altIdFlag,
      .ramDiagErr, .senseRd, .senseCode, .msgCode, .msgValid, .abortCmd, .busy);

   // 50 MHz clock
   initial begin
      clk_sys = 1'b0;
      forever #10 clk_sys = ~clk_sys;
   end

   // hang guard: the whole run needs well under 2000 cycles
   always @(posedge clk_sys) begin
      cycles++;
      if (cycles == 20000) begin
         errCount++;
         summarize();
      end
   end

   task automatic summarize();
      $display("compared %0d mismatches %0d", nCompared, errCount);
      if (errCount == 0 && nCompared > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask

   // one-cycle event pulse, then settle just past the sampling edge
   task automatic strobe(input int k);
      @(posedge clk_sys);
      case (k)
         FMT: fmtErr <= 1'b1;
         IDV: idValid <= 1'b1;
         DAT: dataDone <= 1'b1;
         ASG: assignReq <= 1'b1;
         DONE: cmdDone <= 1'b1;
         default: ramDiagErr <= 1'b1;
      endcase
      @(posedge clk_sys);
      {fmtErr, idValid, dataDone, assignReq, cmdDone, ramDiagErr} <= '0;
      #1;
   endtask

   // bounded wait for the completion pulse, then judge the byte
   task automatic waitMsg(input logic [7:0] exp, input logic ab);
      #1;
      for (int i = 0; i < 300 && msgValid !== 1'b1; i++) @(posedge clk_sys) #1;
      `CHK("msgValid", 1'b1, msgValid)
      `CHK("msgCode", exp, msgCode)
      `CHK("senseCode", exp, senseCode)
      `CHK("abortCmd", ab, abortCmd)
      `CHK("busy", 1'b0, busy)
   endtask

   // rejected commands: bad opcode, one cylinder past range, bad parameter
   task automatic t_reject();
      logic [7:0] e [3] = '{8'h20, 8'h21, 8'h22};
      for (int k = 0; k < 3; k++) begin
         paramBad <= (k == 2);
         host.issue((k == 0) ? 8'h40 : CMD_READ, (k == 1) ? 16'h0065 : 16'h0064, 8'h01);
         waitMsg(e[k], 1'b0);
      end
      paramBad <= 1'b0;
      $display("test reject done");
   endtask

   // search outcomes from ID fields: wrong head, flagged track, ID ECC
   task automatic t_ids();
      logic [7:0] e [3] = '{8'h15, 8'h19, 8'h1A};
      for (int k = 0; k < 3; k++) begin
         host.issue(CMD_WRITE, 16'h0005, 8'h01);
         id       <= '{'{16'h0005, (k == 0) ? 8'h02 : 8'h01}, 8'h03, 1'b0, (k == 1)};
         idEccErr <= (k == 2);
         strobe(IDV);
         `CHK("senseCode", e[k], senseCode)
         idEccErr <= 1'b0;
         if (k == 2) strobe(FMT);
         strobe(DONE);
         waitMsg(e[k], 1'b0);
      end
      $display("test id fields done");
   endtask

   // span at burst length corrects, one more does not; clean retry is transient
   task automatic t_data();
      logic [7:0] e [3] = '{8'h18, 8'h11, 8'h1B};
      host.issue(CMD_READ, 16'h0005, 8'h01);
      for (int k = 0; k < 3; k++) begin
         dataErr   <= (k < 2);
         errSpan   <= 8'h08 + 8'(k);
         retryRead <= (k == 2);
         strobe(DAT);
         `CHK("senseCode", e[k], senseCode)
      end
      retryRead <= 1'b0;
      strobe(DONE);
      waitMsg(8'h1B, 1'b0);
      $display("test data done");
   endtask

   // alternate checks: same track, taken, defective, missing flag
   task automatic t_alt();
      logic [7:0] e [4] = '{8'h1F, 8'h1D, 8'h1D, 8'h1E};
      host.issue(CMD_READ, 16'h0005, 8'h01);
      for (int k = 0; k < 4; k++) begin
         altTrk      <= '{(k == 0) ? 16'h0005 : 16'h0060, 8'h01}; // spare never freed
         altAssigned <= (k == 1);
         altIsBad    <= (k == 2);
         altIdFlag   <= (k != 3);
         strobe(ASG);
         `CHK("senseCode", e[k], senseCode)
      end
      strobe(DONE);
      waitMsg(8'h1E, 1'b0);
      $display("test alternate done");
   endtask

   // no mark for exactly the window length, then the code lands
   task automatic t_amiss();
      host.readSense();
      host.issue(CMD_READ, 16'h0005, 8'h01);
      repeat (99) @(posedge clk_sys);
      #1;
      `CHK("senseCode", 8'h00, senseCode)
      @(posedge clk_sys) #1;
      `CHK("senseCode", 8'h12, senseCode)
      strobe(DONE);
      waitMsg(8'h12, 1'b0);
      $display("test mark window done");
   endtask

   // one index pass is not enough, the second ends the search
   task automatic t_notfound();
      host.readSense();
      host.issue(CMD_READ, 16'h0005, 8'h01);
      for (int k = 0; k < 2; k++) begin
         @(posedge clk_sys) indexPin <= 1'b1;
         repeat (2) @(posedge clk_sys);
         indexPin <= 1'b0;
         repeat (5) @(posedge clk_sys);
         #1;
         `CHK("senseCode", (k == 1) ? 8'h14 : 8'h00, senseCode)
      end
      strobe(DONE);
      waitMsg(8'h14, 1'b0);
      $display("test not found done");
   endtask

   // twenty errors are tolerated, the twenty-first aborts
   task automatic t_count();
      host.issue(CMD_READ, 16'h0005, 8'h01);
      repeat (20) strobe(FMT);
      `CHK("busy", 1'b1, busy)
      strobe(FMT);
      waitMsg(8'h33, 1'b1);
      $display("test error count done");
   endtask

   // idle diagnostic error is sticky until the host reads status
   task automatic t_sense();
      strobe(RAM);
      `CHK("senseCode", 8'h30, senseCode)
      `CHK("msgValid", 1'b0, msgValid)
      repeat (3) @(posedge clk_sys);
      host.readSense();
      #1;
      `CHK("senseCode", 8'h00, senseCode)
      host.issue(CMD_READ, 16'h0005, 8'h01);
      strobe(DONE);
      waitMsg(8'h00, 1'b0);
      $display("test sense done");
   endtask

   // main sequence
   initial begin
      rst = 1'b1;
      {paramBad, cmdDone, indexPin, addrMarkPin, idValid, idEccErr, fmtErr} = '0;
      {dataDone, dataErr, retryRead, assignReq, altAssigned, altIsBad, altIdFlag} = '0;
      {ramDiagErr, errSpan, id, altTrk} = '0;
      cfg = '{16'h0064, 8'h04, 8'h08};
      repeat (5) @(posedge clk_sys);
      rst <= 1'b0;
      #1;
      `CHK("senseCode", 8'h00, senseCode)
      `CHK("busy", 1'b0, busy)
      t_reject();
      t_ids();
      t_data();
      t_alt();
      t_amiss();
      t_notfound();
      t_count();
      t_sense();
      summarize();
   end
endmodule
